// ---- logic/hpac_core.sv ----
/*
 * hpac_core: pointer/joystick controller core. Samples three axes from a
 * serial converter, calibrates, centres and reports them as joystick or
 * mouse data over Avalon-MM, manages sensor power, suspend and wakeup.
 * Assumes a USB engine that reads the report registers, drives
 * usb_activity and forwards usb_wakeup; converter link on link_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module hpac_core #(
	parameter int SUSPEND_CYCLES = hpac_pkg::SUSPEND_CYC,
	parameter int SAMPLE_CYCLES  = hpac_pkg::SAMPLE_CYC,
	parameter int SETTLE_CYCLES  = hpac_pkg::SETTLE_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// strap and button pins
	input  wire logic [5:0]  button_inputs,
	input  wire logic        joy_mode_n,
	input  wire logic        range_n,
	input  wire logic        center_n,
	input  wire logic        raw_strap,
	// usb engine
	input  wire logic        usb_activity,
	output logic             usb_wakeup,
	// converter link, open drain outputs
	input  wire logic        link_clk,
	output logic             adc_cs_n_o,
	output logic             adc_cs_n_oe,
	output logic             adc_sclk_o,
	output logic             adc_sclk_oe,
	output logic             adc_dout_o,
	output logic             adc_dout_oe,
	input  wire logic        adc_din,
	// sensor power, open drain
	output logic             sensor_en_n_o,
	output logic             sensor_en_n_oe
);
	// pin synchronisers: buttons, straps, bus activity
	logic [10:0] pin_s1_reg, pin_s2_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// pins start at their pull levels: raw strap low, all others high
			pin_s1_reg <= 11'h5ff;
			pin_s2_reg <= 11'h5ff;
		end else begin
			pin_s1_reg <= {usb_activity, raw_strap, center_n, range_n, joy_mode_n, button_inputs};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire [5:0] btn      = ~pin_s2_reg[5:0];
	wire       joy_s    = ~pin_s2_reg[6];
	wire       range_s  = pin_s2_reg[7];
	wire       recen_s  = pin_s2_reg[8];
	wire       raw_s    = pin_s2_reg[9];
	wire       active_s = pin_s2_reg[10];

	// bus slave: one wait cycle, answer on the second
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic        rwake_en_reg;
	wire req_new  = (avs_read | avs_write) & wait_reg;
	wire wr_fire  = avs_write & ~wait_reg;
	wire mclr     = avs_read & ~wait_reg & (avs_address == hpac_pkg::REG_MOUSE);

	// control state
	hpac_pkg::hpac_state_t state_reg, state_next;
	logic        pwr_on_reg, en_n_reg, wake_reg;
	logic        req_tgl_reg;
	logic [7:0]  cmd_reg;
	logic [1:0]  ch_reg;
	logic [31:0] tmr_reg, idle_reg;
	logic [1:0]  ack_s1_reg, ack_s2_reg;
	logic [7:0]  rx_data;
	logic        ack_tgl;
	wire pending   = ack_s2_reg[0] ^ req_tgl_reg;
	wire susp_det  = idle_reg >= 32'(SUSPEND_CYCLES);
	wire tmr_done  = tmr_reg == 32'h0;
	wire proc_fire = (state_reg == hpac_pkg::ST_CONV) & ~pending;
	wire issue     = (state_reg == hpac_pkg::ST_IDLE & tmr_done & ~susp_det)
		| (proc_fire & ch_reg != 2'h2)
		| (state_reg == hpac_pkg::ST_IDLE & susp_det)
		| (state_reg == hpac_pkg::ST_WAKE_PWR & tmr_done);
	wire [1:0] ch_next = (state_reg == hpac_pkg::ST_CONV) ? ch_reg + 2'h1 : 2'h0;
	wire [1:0] pd_next = (state_reg == hpac_pkg::ST_IDLE & susp_det) ? hpac_pkg::PD_SLEEP : hpac_pkg::PD_RUN;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hpac_pkg::ST_WAKE_PWR: begin
				if (tmr_done)
					state_next = hpac_pkg::ST_WAKE_ADC;
			end
			hpac_pkg::ST_WAKE_ADC: begin
				if (!pending)
					state_next = hpac_pkg::ST_IDLE;
			end
			hpac_pkg::ST_IDLE: begin
				if (susp_det)
					state_next = hpac_pkg::ST_SUSP_ADC;
				else if (tmr_done)
					state_next = hpac_pkg::ST_CONV;
			end
			hpac_pkg::ST_CONV: begin
				if (proc_fire && ch_reg == 2'h2)
					state_next = hpac_pkg::ST_IDLE;
			end
			hpac_pkg::ST_SUSP_ADC: begin
				if (!pending)
					state_next = hpac_pkg::ST_SLEEP;
			end
			hpac_pkg::ST_SLEEP: begin
				if (active_s)
					state_next = hpac_pkg::ST_WAKE_PWR;
			end
			default: state_next = hpac_pkg::ST_WAKE_PWR;
		endcase
	end

	// power must be up before the converter is woken; drop only once it sleeps
	wire pwr_next = (state_next != hpac_pkg::ST_SLEEP);
	wire reload   = (state_reg == hpac_pkg::ST_SLEEP) | (proc_fire & ch_reg == 2'h2);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= hpac_pkg::ST_WAKE_PWR;
			pwr_on_reg  <= 1'b1;
			en_n_reg    <= 1'b0;
			req_tgl_reg <= 1'b0;
			cmd_reg     <= 8'h00;
			ch_reg      <= 2'h0;
			tmr_reg     <= 32'(SETTLE_CYCLES);
			idle_reg    <= 32'h0;
			ack_s1_reg  <= 2'h0;
			ack_s2_reg  <= 2'h0;
			wake_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			pwr_on_reg <= pwr_next;
			en_n_reg   <= ~pwr_next;
			ack_s1_reg <= {1'b0, ack_tgl};
			ack_s2_reg <= ack_s1_reg;
			idle_reg   <= active_s ? 32'h0 : (susp_det ? idle_reg : idle_reg + 32'h1);
			if (state_reg == hpac_pkg::ST_SLEEP)
				tmr_reg <= 32'(SETTLE_CYCLES);
			else if (reload)
				tmr_reg <= 32'(SAMPLE_CYCLES);
			else if (!tmr_done)
				tmr_reg <= tmr_reg - 32'h1;
			if (issue) begin
				req_tgl_reg <= ~req_tgl_reg;
				ch_reg      <= ch_next;
				cmd_reg     <= {1'b1, ch_next, 3'h0, pd_next};
			end
			// wakeup held until the host answers with bus activity; a press in that cycle wins
			if (state_reg == hpac_pkg::ST_SLEEP && rwake_en_reg && |btn)
				wake_reg <= 1'b1;
			else if (active_s)
				wake_reg <= 1'b0;
		end
	end

	// per-axis calibration, centring and mouse accumulation
	function automatic logic [2:0] span_shift(input logic [7:0] s);
		logic [2:0] sh;
		sh = 3'h7;
		for (int k = 0; k < 8; k++)
			if (s[k])
				sh = 3'(7 - k);
		return sh;
	endfunction

	logic [7:0] joy_val [3];
	logic [7:0] acc     [3];
	logic [7:0] center  [3];
	logic       acc_fire_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			acc_fire_reg <= 1'b0;
		else
			acc_fire_reg <= proc_fire & ch_reg == 2'h2;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_axis
			logic [7:0] smp_reg, cen_reg, min_reg, max_reg, acc_reg;
			logic [9:0] still_reg;
			wire               hit   = proc_fire & (ch_reg == 2'(gi));
			wire        [7:0]  diff  = (rx_data > smp_reg) ? rx_data - smp_reg : smp_reg - rx_data;
			wire               still = diff <= hpac_pkg::RECENTER_TOL;
			wire signed [8:0]  dr    = $signed({1'b0, smp_reg}) - $signed({1'b0, cen_reg});
			wire signed [15:0] sc    = 16'(dr) <<< span_shift(max_reg - min_reg);
			wire signed [7:0]  cal   = (sc > 16'sd127) ? 8'sd127 : ((sc < -16'sd127) ? -8'sd127 : 8'(sc));
			wire signed [7:0]  jv    = raw_s ? $signed(smp_reg ^ 8'h80) : cal;
			wire        [7:0]  mag   = jv[7] ? 8'(-jv) : 8'(jv);
			// doubled gain on the sensitivity strap; joystick path untouched
			wire signed [7:0]  md    = (mag < hpac_pkg::DEAD_ZONE) ? 8'sh00 : (range_s ? jv >>> 2 : jv >>> 1);
			wire        [7:0]  add   = (acc_fire_reg & ~joy_s) ? 8'(md) : 8'h00;
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					smp_reg   <= hpac_pkg::CENTER_RST;
					cen_reg   <= hpac_pkg::CENTER_RST;
					min_reg   <= hpac_pkg::MIN_RST;
					max_reg   <= hpac_pkg::MAX_RST;
					still_reg <= 10'h000;
					acc_reg   <= 8'h00;
				end else begin
					// a read that clears never drops a motion arriving in the same cycle
					acc_reg <= mclr ? add : acc_reg + add;
					if (hit) begin
						smp_reg   <= rx_data;
						still_reg <= still ? still_reg + 10'h001 : 10'h000;
						if (!raw_s) begin
							if (rx_data < min_reg)
								min_reg <= rx_data;
							if (rx_data > max_reg)
								max_reg <= rx_data;
							if (recen_s && still && still_reg >= hpac_pkg::RECENTER_SAMPLES
								&& rx_data != cen_reg) begin
								cen_reg   <= rx_data;
								still_reg <= 10'h000;
							end
						end
					end
				end
			end
			assign joy_val[gi] = 8'(jv) ^ 8'h80;
			assign acc[gi]     = acc_reg;
			assign center[gi]  = cen_reg;
		end
	endgenerate

	// register read mux
	wire [31:0] st_word = {18'h0, btn, 1'b0, wake_reg, recen_s, range_s, raw_s, pwr_on_reg,
		state_reg == hpac_pkg::ST_SLEEP, joy_s};
	wire [31:0] rd_mux =
		(avs_address == hpac_pkg::REG_CTRL)   ? {31'h0, rwake_en_reg} :
		(avs_address == hpac_pkg::REG_STATUS) ? st_word :
		(avs_address == hpac_pkg::REG_JOY)    ? {2'h0, btn, joy_val[2], joy_val[1], joy_val[0]} :
		(avs_address == hpac_pkg::REG_MOUSE)  ? {acc[2], acc[1], acc[0], 2'h0, btn} :
		(avs_address == hpac_pkg::REG_CONFIG) ? {hpac_pkg::DEVICE_ID, 6'h0, hpac_pkg::FUNC_MASK,
			hpac_pkg::POWER_UNITS} : 32'h0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg     <= 1'b1;
			rdata_reg    <= 32'h0;
			rwake_en_reg <= 1'b0;
		end else begin
			wait_reg <= ~req_new;
			if (req_new)
				rdata_reg <= avs_read ? rd_mux : 32'h0;
			if (wr_fire && avs_address == hpac_pkg::REG_CTRL)
				rwake_en_reg <= avs_writedata[hpac_pkg::CTRL_RWAKE_BIT];
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign usb_wakeup      = wake_reg;
	assign sensor_en_n_o   = en_n_reg;
	assign sensor_en_n_oe  = pwr_on_reg;

	// link domain: serial shifter on link_clk
	logic       lrst_s1_reg, lrst_n;
	logic       rq_s1_reg, rq_s2_reg, rq_seen_reg, ack_reg;
	logic [1:0] din_s_reg;
	logic [15:0] sh_reg;
	logic [4:0] bit_reg;
	logic [1:0] sub_reg;
	logic [7:0] res_reg;
	logic       cs_reg, sclk_reg, dout_reg;
	hpac_pkg::hpac_link_t lk_reg;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_s1_reg <= 1'b0;
			lrst_n      <= 1'b0;
		end else begin
			lrst_s1_reg <= 1'b1;
			lrst_n      <= lrst_s1_reg;
		end
	end

	wire lk_start = (lk_reg == hpac_pkg::LK_IDLE) & (rq_s2_reg != rq_seen_reg);
	wire lk_last  = (lk_reg == hpac_pkg::LK_SHIFT) & (sub_reg == 2'h3) & (bit_reg == hpac_pkg::XFER_BITS - 5'h1);

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			rq_s1_reg   <= 1'b0;
			rq_s2_reg   <= 1'b0;
			rq_seen_reg <= 1'b0;
			ack_reg     <= 1'b0;
			din_s_reg   <= 2'h3;
			sh_reg      <= 16'h0;
			bit_reg     <= 5'h0;
			sub_reg     <= 2'h0;
			res_reg     <= 8'h0;
			cs_reg      <= 1'b1;
			sclk_reg    <= 1'b0;
			dout_reg    <= 1'b1;
			lk_reg      <= hpac_pkg::LK_IDLE;
		end else begin
			rq_s1_reg <= req_tgl_reg;
			rq_s2_reg <= rq_s1_reg;
			din_s_reg <= {din_s_reg[0], adc_din};
			if (lk_start) begin
				// command is stable while the request toggle is pending
				sh_reg      <= {cmd_reg, 8'h00};
				rq_seen_reg <= rq_s2_reg;
				bit_reg     <= 5'h0;
				sub_reg     <= 2'h0;
				cs_reg      <= 1'b0;
				lk_reg      <= hpac_pkg::LK_SHIFT;
			end else if (lk_reg == hpac_pkg::LK_SHIFT) begin
				sub_reg  <= sub_reg + 2'h1;
				// sclk rises a link cycle after dout moves, never on the same edge
				sclk_reg <= (sub_reg == 2'h1) | (sub_reg == 2'h2);
				if (sub_reg == 2'h0)
					dout_reg <= sh_reg[15];
				if (sub_reg == 2'h3) begin
					sh_reg  <= {sh_reg[14:0], din_s_reg[1]};
					bit_reg <= bit_reg + 5'h1;
				end
				if (lk_last) begin
					res_reg <= {sh_reg[6:0], din_s_reg[1]};
					ack_reg <= ~ack_reg;
					cs_reg  <= 1'b1;
					lk_reg  <= hpac_pkg::LK_IDLE;
				end
			end
		end
	end

	assign ack_tgl     = ack_reg;
	assign rx_data     = res_reg;
	assign adc_cs_n_o  = cs_reg;
	assign adc_cs_n_oe = ~cs_reg;
	assign adc_sclk_o  = sclk_reg;
	assign adc_sclk_oe = ~sclk_reg;
	assign adc_dout_o  = dout_reg;
	assign adc_dout_oe = ~dout_reg;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_susp_begin;
		state_reg == hpac_pkg::ST_IDLE && susp_det;
	endsequence
	sequence s_adc_asleep;
		state_reg == hpac_pkg::ST_SUSP_ADC && !pending;
	endsequence

	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	suspend_start_a: assert property (s_susp_begin |=> state_reg == hpac_pkg::ST_SUSP_ADC && pwr_on_reg)
		else $error("suspend did not start with power still on");
	sleep_order_a: assert property (s_adc_asleep |=> state_reg == hpac_pkg::ST_SLEEP && !sensor_en_n_oe)
		else $error("sensor power not dropped after converter sleep");
	power_off_a: assert property (state_reg == hpac_pkg::ST_SLEEP |-> !pwr_on_reg && sensor_en_n_o)
		else $error("sensor enable driven while asleep");
	wake_power_a: assert property (state_reg == hpac_pkg::ST_WAKE_ADC |-> sensor_en_n_oe && !sensor_en_n_o)
		else $error("converter woken without sensor power");
	wake_gate_a: assert property ($rose(usb_wakeup) |-> $past(rwake_en_reg && |btn && state_reg == hpac_pkg::ST_SLEEP))
		else $error("wakeup without enable, press and suspend");
	joy_no_mouse_a: assert property (joy_s && !mclr |=> $stable(g_axis[0].acc_reg))
		else $error("mouse motion accumulated in joystick mode");
	raw_center_a: assert property (raw_s && proc_fire |=> $stable(center[0]) && $stable(center[1]))
		else $error("centre moved in raw mode");
	center_off_a: assert property (!recen_s && proc_fire |=> $stable(center[0]) && $stable(center[2]))
		else $error("centre moved with recentring off");
	frame_low_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$fell(cs_reg) |-> !cs_reg [*8])
		else $error("converter frame ended early");
endmodule
`default_nettype wire

// ---- logic/hpac_pkg.sv ----
/*
 * hpac_pkg: constants, register map and state encodings of the hybrid
 * pointer axis controller.
 * Assumes a 100 MHz system clock; long counts are overridable at the top.
 */
package hpac_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// bus idle time before suspend, sample interval, sensor settle time
	localparam int SUSPEND_US    = 3000;
	localparam int SUSPEND_CYC   = (SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_US     = 1000;
	localparam int SAMPLE_CYC    = (SAMPLE_US * 1000) / CLK_PERIOD_NS;
	localparam int SETTLE_US     = 1000;
	localparam int SETTLE_CYC    = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// recentering: samples an axis must stay still, and what counts as still; then the mouse dead zone
	localparam logic [9:0] RECENTER_SAMPLES = 10'h1f4;
	localparam logic [7:0] RECENTER_TOL     = 8'h02;
	localparam logic [7:0] DEAD_ZONE        = 8'h04;
	// register byte offsets
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_JOY    = 5'h08;
	localparam logic [4:0] REG_MOUSE  = 5'h0c;
	localparam logic [4:0] REG_CONFIG = 5'h10;
	// field positions
	localparam int CTRL_RWAKE_BIT = 0;
	localparam int ST_JOY_BIT     = 0;
	localparam int ST_SUSP_BIT    = 1;
	localparam int ST_PWR_BIT     = 2;
	localparam int ST_RAW_BIT     = 3;
	localparam int ST_RANGE_BIT   = 4;
	localparam int ST_CENTER_BIT  = 5;
	localparam int ST_WAKE_BIT    = 6;
	localparam int ST_BTN_POS     = 8;
	// reset values
	localparam logic [7:0] CENTER_RST = 8'h80;
	localparam logic [7:0] MIN_RST    = 8'h60;
	localparam logic [7:0] MAX_RST    = 8'ha0;
	// configuration: bus power in 2 mA units (100 mA), joystick + mouse
	localparam logic [7:0]  POWER_UNITS = 8'h32;
	localparam logic [1:0]  FUNC_MASK   = 2'h3;
	localparam logic [15:0] DEVICE_ID   = 16'h5a01;  // arbitrary value
	// converter command byte: start, channel, power-down field
	localparam logic [1:0] PD_RUN   = 2'h3;
	localparam logic [1:0] PD_SLEEP = 2'h0;
	localparam logic [4:0] XFER_BITS = 5'h10;

	typedef enum logic [2:0] {
		ST_WAKE_PWR = 3'b000,
		ST_WAKE_ADC = 3'b001,
		ST_IDLE     = 3'b010,
		ST_CONV     = 3'b011,
		ST_SUSP_ADC = 3'b100,
		ST_SLEEP    = 3'b101
	} hpac_state_t;

	typedef enum logic [0:0] {
		LK_IDLE  = 1'b0,
		LK_SHIFT = 1'b1
	} hpac_link_t;
endpackage

// ---- testbench/hpac_adc_model.sv ----
/*
 * hpac_adc_model: behavioural serial converter on the axis link.
 * Assumes wire levels already resolved from the open drain enables (pull-ups).
 */
`timescale 1ns/1ns
`default_nettype none
module hpac_adc_model (
	// link wires
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       dout,
	output logic            din,
	// result per channel
	input  wire logic [7:0] val0,
	input  wire logic [7:0] val1,
	input  wire logic [7:0] val2
);
	int         cnt = 0;
	int         frames = 0;
	int         sets = 0;
	logic [7:0] cmd = 8'h00;
	logic [7:0] last_cmd = 8'h00;
	logic [7:0] res;

	assign res = (cmd[6:5] == 2'h0) ? val0 : (cmd[6:5] == 2'h1) ? val1 : val2;

	initial din = 1'b1;
	// outside the result bits din rests at its pull-up level
	always @(negedge cs_n) begin
		cnt = 0;
		din = 1'b1;
	end
	always @(posedge cs_n) begin
		frames++;
		last_cmd = cmd;
		if (cmd[6:5] == 2'h2)
			sets++;
		din = 1'b1;
	end
	always @(posedge sclk) begin
		if (!cs_n && cnt < 8)
			cmd = {cmd[6:0], dout};
	end
	// moved on the falling sclk so each bit is steady long before the late sample
	always @(negedge sclk) begin
		if (!cs_n) begin
			cnt++;
			din = (cnt >= 8 && cnt < 16) ? res[15 - cnt] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/hybrid_pointer_axis_controller_bench.sv ----
/*
 * hybrid_pointer_axis_controller_bench: self-checking bench for hpac_core.
 * Assumes shortened core counts and the converter model on the link.
 */
`timescale 1ns/1ns
`default_nettype none
module hybrid_pointer_axis_controller_bench;
	logic        sys_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [5:0]  button_inputs = 6'h3f;
	logic        joy_mode_n = 1'b0;
	logic        range_n = 1'b1;
	logic        center_n = 1'b1;
	logic        raw_strap = 1'b0;
	logic        usb_activity = 1'b1;
	logic        usb_wakeup;
	logic        cs_oe;
	logic        sclk_oe;
	logic        dout_oe;
	logic        en_oe;
	logic        en_o;
	logic        adc_din;
	logic [7:0]  val0 = 8'h80;
	logic [7:0]  val1 = 8'h80;
	logic [7:0]  val2 = 8'h80;
	logic [31:0] rd;
	int          fails = 0;
	int          cmp_count = 0;

	always #5 sys_clk = ~sys_clk;
	// link edges fall on multiples of 80 ns, never on a rising system clock edge
	always #80 link_clk = ~link_clk;

	// shortened suspend, sample and settle counts keep the run short
	hpac_core #(.SUSPEND_CYCLES(400), .SAMPLE_CYCLES(200), .SETTLE_CYCLES(50)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .button_inputs(button_inputs), .joy_mode_n(joy_mode_n),
		.range_n(range_n), .center_n(center_n), .raw_strap(raw_strap), .usb_activity(usb_activity),
		.usb_wakeup(usb_wakeup), .link_clk(link_clk), .adc_cs_n_o(), .adc_cs_n_oe(cs_oe),
		.adc_sclk_o(), .adc_sclk_oe(sclk_oe), .adc_dout_o(), .adc_dout_oe(dout_oe),
		.adc_din(adc_din), .sensor_en_n_o(en_o), .sensor_en_n_oe(en_oe));

	hpac_adc_model adc (.cs_n(~cs_oe), .sclk(~sclk_oe), .dout(~dout_oe), .din(adc_din),
		.val0(val0), .val1(val1), .val2(val2));

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask

	task automatic chk_true(input string what, input logic cond);
		cmp_count++;
		if (cond !== 1'b1) begin
			$display("wrong value %s expected 1 seen %b", what, cond);
			fails++;
		end
	endtask

	task automatic give_up(input string what);
		$display("wrong value %s expected answer seen timeout", what);
		fails++;
		end_sim();
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
			give_up("bus answer");
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	// two set completions, so at least one whole three-channel set follows the start
	task automatic wait_set();
		int s0;
		int n;
		s0 = adc.sets;
		n = 0;
		while (adc.sets < s0 + 2 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20000)
			give_up("sample sets");
		repeat (100) @(posedge sys_clk);
	endtask

	task automatic t_config();
		chk_true("sensor power after reset", en_oe);
		chk_true("sensor enable driven low", en_o === 1'b0);
		bus_xfer(1'b1, 5'h10, 32'h0);
		bus_xfer(1'b0, 5'h10, 32'h0);
		chk("bus power", 32'h32, rd & 32'hff);
		chk("functions", 32'h3, (rd >> 8) & 32'h3);
		bus_xfer(1'b0, 5'h14, 32'h0);
		chk("unmapped read", 32'h0, rd);
		bus_xfer(1'b1, 5'h00, 32'h1);
		bus_xfer(1'b0, 5'h00, 32'h0);
		chk("wakeup enable", 32'h1, rd & 32'h1);
	endtask

	task automatic t_buttons();
		button_inputs <= 6'h2a;
		repeat (4) @(posedge sys_clk);
		bus_xfer(1'b0, 5'h04, 32'h0);
		chk("status buttons", 32'h15, (rd >> 8) & 32'h3f);
		bus_xfer(1'b0, 5'h08, 32'h0);
		chk("joystick buttons", 32'h15, (rd >> 24) & 32'h3f);
		button_inputs <= 6'h3f;
	endtask

	task automatic t_axes();
		wait_set();
		bus_xfer(1'b0, 5'h08, 32'h0);
		chk("centred axes", 32'h808080, rd & 32'hffffff);
		raw_strap <= 1'b1;
		val0 <= 8'h11;
		val1 <= 8'h22;
		val2 <= 8'h33;
		wait_set();
		bus_xfer(1'b0, 5'h08, 32'h0);
		chk("raw axes", 32'h332211, rd & 32'hffffff);
		chk("convert command", 32'hc3, {24'h0, adc.last_cmd} & 32'he3);
		raw_strap <= 1'b0;
	endtask

	task automatic t_modes();
		logic [31:0] m1;
		val0 <= 8'hc0;
		val1 <= 8'h40;
		val2 <= 8'h80;
		joy_mode_n <= 1'b1;
		wait_set();
		bus_xfer(1'b0, 5'h04, 32'h0);
		chk("mouse mode flag", 32'h0, rd & 32'h1);
		bus_xfer(1'b0, 5'h0c, 32'h0);
		wait_set();
		bus_xfer(1'b0, 5'h0c, 32'h0);
		m1 = rd;
		chk_true("cursor x right", m1[15] === 1'b0 && m1[15:8] !== 8'h00);
		chk_true("cursor y back", m1[23]);
		range_n <= 1'b0;
		wait_set();
		bus_xfer(1'b0, 5'h0c, 32'h0);
		wait_set();
		bus_xfer(1'b0, 5'h0c, 32'h0);
		chk_true("doubled gain", rd[15:8] > m1[15:8]);
		joy_mode_n <= 1'b0;
		center_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		bus_xfer(1'b0, 5'h04, 32'h0);
		chk("joystick mode flag", 32'h1, rd & 32'h1);
		chk("recentre off flag", 32'h0, rd & 32'h20);
		bus_xfer(1'b0, 5'h0c, 32'h0);
		wait_set();
		bus_xfer(1'b0, 5'h08, 32'h0);
		m1 = rd;
		bus_xfer(1'b0, 5'h0c, 32'h0);
		chk("no cursor motion", 32'h0, rd & 32'hffffff00);
		range_n <= 1'b1;
		wait_set();
		bus_xfer(1'b0, 5'h08, 32'h0);
		chk("joystick ignores gain", m1 & 32'hffffff, rd & 32'hffffff);
		center_n <= 1'b1;
	endtask

	task automatic t_suspend(input logic wake_en);
		int n;
		int f0;
		n = 0;
		bus_xfer(1'b1, 5'h00, {31'h0, wake_en});
		usb_activity <= 1'b0;
		while (en_oe !== 1'b0 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20000)
			give_up("sensor power off");
		chk("converter asleep first", 32'h0, {24'h0, adc.last_cmd} & 32'h3);
		chk_true("sensor enable released", en_o === 1'b1);
		repeat (4) @(posedge sys_clk);
		bus_xfer(1'b0, 5'h04, 32'h0);
		chk("suspended without power", 32'h2, rd & 32'h6);
		f0 = adc.frames;
		button_inputs <= 6'h3e;
		repeat (40) @(posedge sys_clk);
		chk("wakeup request", {31'h0, wake_en}, {31'h0, usb_wakeup});
		button_inputs <= 6'h3f;
		usb_activity <= 1'b1;
		n = 0;
		while (en_oe !== 1'b1 && n < 1000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 1000)
			give_up("sensor power on");
		chk("power before converter wake", f0, adc.frames);
		n = 0;
		while (adc.frames == f0 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		if (adc.frames == f0)
			give_up("wake frame");
		chk("converter woken", 32'h3, {24'h0, adc.last_cmd} & 32'h3);
		chk_true("wakeup dropped", usb_wakeup === 1'b0);
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_config();
		t_buttons();
		t_axes();
		t_modes();
		t_suspend(1'b1);
		t_suspend(1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
